//--- io_channel_map.vh
`ifndef IO_CHANNEL_MAP_VH
`define IO_CHANNEL_MAP_VH

// ----------------------------------------------------------------------
// pointer byte modes (upper nibble)
// ----------------------------------------------------------------------
`define PTR_MODE_CONFIG   4'h0
`define PTR_MODE_DAC_WR   4'h1
`define PTR_MODE_ADC_RD   4'h4
`define PTR_MODE_DAC_RD   4'h5
`define PTR_MODE_GPIO_RD  4'h6
`define PTR_MODE_REG_RD   4'h7

// ----------------------------------------------------------------------
// control register indices (lower nibble)
// ----------------------------------------------------------------------
`define REG_ADC_SEQ       4'h2
`define REG_GEN_CTRL      4'h3
`define REG_ADC_CFG       4'h4
`define REG_DAC_CFG       4'h5
`define REG_LOAD_MODE     4'h7
`define REG_GPO_CFG       4'h8
`define REG_GPO_DATA      4'h9
`define REG_GPI_CFG       4'hA
`define REG_OD_CFG        4'hC
`define REG_SW_RESET      4'hF

// ----------------------------------------------------------------------
// reset values, keys and field positions
// ----------------------------------------------------------------------
`define RESET_WORD        16'h0000
`define RESET_BYTE        8'h00
`define RESET_MASK        9'h000
`define RESET_CODE        12'h000
`define SW_RESET_KEY      16'h0DAC
`define LOCK_BIT          7
`define SEQ_TEMP_BIT      8
`define SEQ_REPEAT_BIT    9
`define LOAD_DIRECT       2'h0
`define LOAD_HOLD         2'h1
`define LOAD_ALL          2'h2
`define TEMP_ADDR         4'h8
`define DAC_TAG           1'h1
`define ADC_TAG           1'h0
`define BYTE_PTR          2'h0
`define BYTE_MSB          2'h1
`define BYTE_LSB          2'h2
`define BYTE_DONE         2'h3

`endif

//--- io_channel_config_dac_adc_gpio.v
`timescale 1ns/1ns
// What this block does
// - lock bit blocks pin configuration writes
// - mode zero pointer selects control register
// - bit n configures channel pin n
// - latest configuration write wins per channel
// - dac plus adc: dac drives, adc monitors
// - input plus output acts as output, readable
// - dac write mode loads selected input register
// - load mode: 00 direct, 01 hold
// - load mode 10 copies all, reverts 01
// - dac readback only without running sequence
// - dac word: tag, address, input value
// - sequence converts lowest channel first
// - conversion starts at ack before msb
// - repeat restarts, otherwise last result repeats
// - adc word: zero tag, address, value
// - new sequence drops pending, starts fresh
// - output enable bit, push/pull follows data
// - open drain drives only low data
// - data bits of non-outputs are ignored
// - write is pointer, msb, lsb bytes
// - input enable; gpio pointer returns inputs
// - temperature bit adds conversion, address 1000
`include "io_channel_map.vh"

// ----------------------------------------------------------------------
// read word fifo
// ----------------------------------------------------------------------
// shift style so the head word sits in a flip-flop
module word_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter CW    = 4
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire             in_valid_i,
  input  wire [WIDTH-1:0] in_data_i,
  output reg              in_ready_o,
  output reg              out_valid_o,
  output wire [WIDTH-1:0] out_data_o,
  input  wire             out_ready_i
);
  localparam [CW-1:0] FULL = DEPTH;
  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [CW-1:0]    count;
  reg  [CW-1:0]    next_count;
  reg  [CW-1:0]    wr_idx;
  wire             push = in_valid_i && in_ready_o;
  wire             pop  = out_valid_o && out_ready_i;
  integer          i;

  assign out_data_o = mem[0];

  always @* begin
    next_count = count;
    wr_idx     = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (!push && pop) begin
      next_count = count - 1'b1;
    end
    if (pop) begin
      wr_idx = count - 1'b1;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count       <= {CW{1'b0}};
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
    end else begin
      count       <= next_count;
      in_ready_o  <= next_count != FULL;
      out_valid_o <= next_count != {CW{1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        if (push && wr_idx == i) begin
          mem[i] <= in_data_i;
        end else if (pop && i < DEPTH - 1) begin
          mem[i] <= mem[i+1];
        end
      end
    end
  end
endmodule

// ----------------------------------------------------------------------
// channel configuration, dac, adc sequencing and gpio
// ----------------------------------------------------------------------
module io_channel_config_dac_adc_gpio #(
  parameter FIFO_DEPTH = 8
) (
  input  wire        CORE_CLK_I,
  input  wire        RST_B_I,
  input  wire        FRAME_START_I,
  input  wire        BYTE_VALID_I,
  input  wire [7:0]  BYTE_I,
  input  wire        READ_REQ_I,
  input  wire        RD_READY_I,
  input  wire        ADC_DONE_I,
  input  wire [11:0] ADC_VALUE_I,
  input  wire [7:0]  CHANNEL_PIN_IN_I,
  output wire [15:0] RD_DATA_O,
  output wire        RD_VALID_O,
  output reg         REQ_READY_O,
  output reg         ADC_START_O,
  output reg  [3:0]  ADC_CHAN_O,
  output reg  [95:0] DAC_VALUE_O,
  output reg  [7:0]  DAC_ENABLE_O,
  output reg  [7:0]  ADC_ENABLE_O,
  output reg  [7:0]  CHANNEL_PIN_OUT_O,
  output reg  [7:0]  CHANNEL_PIN_OE_B_O
);
  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;

  reg  [1:0]  rst_sync;
  wire        rst_n = rst_sync[1];
  reg         sw_rst;
  reg  [1:0]  state;
  reg  [7:0]  ptr;
  reg  [7:0]  msb;
  reg  [1:0]  byte_cnt;
  reg  [15:0] gen_ctrl;
  reg  [15:0] adc_seq;
  reg  [7:0]  gpo_cfg;
  reg  [7:0]  gpi_cfg;
  reg  [7:0]  od_cfg;
  reg  [7:0]  gpo_data;
  reg  [1:0]  load_mode;
  reg  [11:0] dac_in [0:7];
  reg  [8:0]  pending;
  reg         seq_fresh;
  reg  [15:0] last_word;
  reg         push;
  reg  [15:0] push_word;
  wire        fifo_ready;
  wire [15:0] wdata = {msb, BYTE_I};
  wire        commit = BYTE_VALID_I && byte_cnt == `BYTE_LSB;
  wire        locked = gen_ctrl[`LOCK_BIT];
  wire        seq_running = adc_seq[`SEQ_TEMP_BIT:0] != `RESET_MASK;
  wire        accept = READ_REQ_I && fifo_ready && !push &&
                       state == ST_IDLE;
  wire [7:0]  pin_state = (gpo_cfg & gpo_data) |
                          (~gpo_cfg & CHANNEL_PIN_IN_I);
  wire [8:0]  seq_sel = adc_seq[`SEQ_TEMP_BIT:0];
  wire [8:0]  rest = pending & ~(9'h001 << ADC_CHAN_O);
  integer     k;

  // lowest pending source, temperature last
  function [3:0] first_bit;
    input [8:0] mask;
    integer     j;
    begin
      first_bit = 4'h0;
      for (j = 8; j >= 0; j = j - 1) begin
        if (mask[j]) begin
          first_bit = j[3:0];
        end
      end
    end
  endfunction

  function [15:0] read_reg;
    input [3:0] idx;
    begin
      case (idx)
        `REG_ADC_SEQ:   read_reg = adc_seq;
        `REG_GEN_CTRL:  read_reg = gen_ctrl;
        `REG_ADC_CFG:   read_reg = {8'h00, ADC_ENABLE_O};
        `REG_DAC_CFG:   read_reg = {8'h00, DAC_ENABLE_O};
        `REG_LOAD_MODE: read_reg = {14'h0000, load_mode};
        `REG_GPO_CFG:   read_reg = {8'h00, gpo_cfg};
        `REG_GPO_DATA:  read_reg = {8'h00, gpo_data};
        `REG_GPI_CFG:   read_reg = {8'h00, gpi_cfg};
        `REG_OD_CFG:    read_reg = {8'h00, od_cfg};
        default:        read_reg = `RESET_WORD;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  // a software reset pulls the same synchroniser so every flop clears
  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_sync <= 2'b00;
    end else if (sw_rst) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // ----------------------------------------------------------------------
  // byte framing and register writes
  // ----------------------------------------------------------------------
  always @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ptr          <= `RESET_BYTE;
      msb          <= `RESET_BYTE;
      byte_cnt     <= `BYTE_PTR;
      gen_ctrl     <= `RESET_WORD;
      adc_seq      <= `RESET_WORD;
      ADC_ENABLE_O <= `RESET_BYTE;
      DAC_ENABLE_O <= `RESET_BYTE;
      gpo_cfg      <= `RESET_BYTE;
      gpi_cfg      <= `RESET_BYTE;
      od_cfg       <= `RESET_BYTE;
      gpo_data     <= `RESET_BYTE;
      load_mode    <= `LOAD_DIRECT;
      DAC_VALUE_O  <= {8{`RESET_CODE}};
      sw_rst       <= 1'b0;
      for (k = 0; k < 8; k = k + 1) begin
        dac_in[k] <= `RESET_CODE;
      end
    end else begin
      if (FRAME_START_I) begin
        byte_cnt <= `BYTE_PTR;
      end else if (BYTE_VALID_I) begin
        if (byte_cnt == `BYTE_PTR) begin
          ptr <= BYTE_I;
        end
        if (byte_cnt == `BYTE_MSB) begin
          msb <= BYTE_I;
        end
        if (byte_cnt != `BYTE_DONE) begin
          byte_cnt <= byte_cnt + 1'b1;
        end
      end
      if (commit && !FRAME_START_I) begin
        if (ptr[7:4] == `PTR_MODE_CONFIG) begin
          case (ptr[3:0])
            `REG_GEN_CTRL: begin
              gen_ctrl <= wdata;
            end
            `REG_ADC_SEQ: begin
              adc_seq <= wdata;
            end
            `REG_LOAD_MODE: begin
              if (wdata[1:0] == `LOAD_ALL) begin
                for (k = 0; k < 8; k = k + 1) begin
                  DAC_VALUE_O[k*12 +: 12] <= dac_in[k];
                end
                load_mode <= `LOAD_HOLD;
              end else begin
                load_mode <= wdata[1:0];
              end
            end
            `REG_GPO_DATA: begin
              gpo_data <= (gpo_data & ~gpo_cfg) |
                          (wdata[7:0] & gpo_cfg);
            end
            `REG_DAC_CFG: begin
              if (!locked) begin
                // dac may share a pin with adc only
                DAC_ENABLE_O <= wdata[7:0];
                gpo_cfg      <= gpo_cfg & ~wdata[7:0];
                gpi_cfg      <= gpi_cfg & ~wdata[7:0];
              end
            end
            `REG_ADC_CFG: begin
              if (!locked) begin
                ADC_ENABLE_O <= wdata[7:0];
                gpo_cfg      <= gpo_cfg & ~wdata[7:0];
                gpi_cfg      <= gpi_cfg & ~wdata[7:0];
              end
            end
            `REG_GPO_CFG: begin
              if (!locked) begin
                gpo_cfg      <= wdata[7:0];
                DAC_ENABLE_O <= DAC_ENABLE_O & ~wdata[7:0];
                ADC_ENABLE_O <= ADC_ENABLE_O & ~wdata[7:0];
              end
            end
            `REG_GPI_CFG: begin
              if (!locked) begin
                gpi_cfg      <= wdata[7:0];
                DAC_ENABLE_O <= DAC_ENABLE_O & ~wdata[7:0];
                ADC_ENABLE_O <= ADC_ENABLE_O & ~wdata[7:0];
              end
            end
            `REG_OD_CFG: begin
              if (!locked) begin
                od_cfg <= wdata[7:0];
              end
            end
            `REG_SW_RESET: begin
              if (wdata == `SW_RESET_KEY) begin
                sw_rst <= 1'b1;
              end
            end
            default: begin
            end
          endcase
        end else if (ptr[7:4] == `PTR_MODE_DAC_WR) begin
          dac_in[ptr[2:0]] <= wdata[11:0];
          if (load_mode == `LOAD_DIRECT) begin
            DAC_VALUE_O[ptr[2:0]*12 +: 12] <= wdata[11:0];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // read requests and adc sequencing
  // ----------------------------------------------------------------------
  always @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ST_IDLE;
      pending     <= `RESET_MASK;
      seq_fresh   <= 1'b0;
      last_word   <= `RESET_WORD;
      push        <= 1'b0;
      push_word   <= `RESET_WORD;
      ADC_START_O <= 1'b0;
      ADC_CHAN_O  <= 4'h0;
      REQ_READY_O <= 1'b0;
    end else begin
      push        <= 1'b0;
      ADC_START_O <= 1'b0;
      REQ_READY_O <= fifo_ready && state == ST_IDLE && !accept && !push;
      case (state)
        ST_IDLE: begin
          if (accept) begin
            seq_fresh <= 1'b0;
            case (ptr[7:4])
              `PTR_MODE_ADC_RD: begin
                if (pending != `RESET_MASK) begin
                  ADC_START_O <= 1'b1;
                  ADC_CHAN_O  <= first_bit(pending);
                  state       <= ST_CONV;
                end else begin
                  push      <= 1'b1;
                  push_word <= last_word;
                end
              end
              `PTR_MODE_DAC_RD: begin
                // refused while a sequence is set; no word is returned
                if (!seq_running) begin
                  push      <= 1'b1;
                  push_word <= {`DAC_TAG, ptr[2:0],
                                dac_in[ptr[2:0]]};
                end
              end
              `PTR_MODE_GPIO_RD: begin
                push      <= 1'b1;
                push_word <= {8'h00, gpi_cfg & pin_state};
              end
              `PTR_MODE_REG_RD: begin
                push      <= 1'b1;
                push_word <= read_reg(ptr[3:0]);
              end
              default: begin
              end
            endcase
          end
        end
        ST_CONV: begin
          if (ADC_DONE_I) begin
            push  <= 1'b1;
            state <= ST_IDLE;
            if (ADC_CHAN_O == `TEMP_ADDR) begin
              push_word <= {`TEMP_ADDR, ADC_VALUE_I};
              last_word <= {`TEMP_ADDR, ADC_VALUE_I};
            end else begin
              push_word <= {`ADC_TAG, ADC_CHAN_O[2:0],
                            ADC_VALUE_I};
              last_word <= {`ADC_TAG, ADC_CHAN_O[2:0], ADC_VALUE_I};
            end
            // a sequence written mid-conversion keeps its full mask
            if (!seq_fresh) begin
              if (rest == `RESET_MASK &&
                  adc_seq[`SEQ_REPEAT_BIT]) begin
                pending <= seq_sel;
              end else begin
                pending <= rest;
              end
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      if (commit && !FRAME_START_I && ptr == {`PTR_MODE_CONFIG,
                                              `REG_ADC_SEQ}) begin
        pending   <= wdata[`SEQ_TEMP_BIT:0];
        seq_fresh <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // gpio pin drive
  // ----------------------------------------------------------------------
  // open drain only pulls low; a high bit releases the pin
  always @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CHANNEL_PIN_OUT_O  <= `RESET_BYTE;
      CHANNEL_PIN_OE_B_O <= 8'hFF;
    end else begin
      CHANNEL_PIN_OUT_O  <= gpo_data & ~od_cfg;
      CHANNEL_PIN_OE_B_O <= ~(gpo_cfg & ~(od_cfg & gpo_data));
    end
  end

  word_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH),
    .CW    (4)
  ) u_fifo (
    .clk_i       (CORE_CLK_I),
    .rst_n_i     (rst_n),
    .in_valid_i  (push),
    .in_data_i   (push_word),
    .in_ready_o  (fifo_ready),
    .out_valid_o (RD_VALID_O),
    .out_data_o  (RD_DATA_O),
    .out_ready_i (RD_READY_I)
  );
endmodule

//--- io_asserts.sv
`timescale 1ns/1ns
module io_asserts (
  input wire        CORE_CLK_I,
  input wire        RST_B_I,
  input wire        BYTE_VALID_I,
  input wire        READ_REQ_I,
  input wire        RD_READY_I,
  input wire        ADC_DONE_I,
  input wire [11:0] ADC_VALUE_I,
  input wire [15:0] RD_DATA_O,
  input wire        RD_VALID_O,
  input wire        ADC_START_O,
  input wire [3:0]  ADC_CHAN_O,
  input wire [95:0] DAC_VALUE_O,
  input wire [7:0]  DAC_ENABLE_O,
  input wire [7:0]  ADC_ENABLE_O,
  input wire [7:0]  CHANNEL_PIN_OUT_O,
  input wire [7:0]  CHANNEL_PIN_OE_B_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  // ----------------------------------------------------------------
  // conversion tracking
  // ----------------------------------------------------------------
  reg        pend;
  reg [3:0]  chan;
  reg [11:0] code;
  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pend <= 1'b0;
      chan <= 4'h0;
      code <= 12'h000;
    end else if (ADC_START_O) begin
      pend <= 1'b1;
      chan <= ADC_CHAN_O;
    end else if (ADC_DONE_I) begin
      pend <= 1'b0;
      code <= ADC_VALUE_I;
    end
  end
  sequence conv_done;
    pend && ADC_DONE_I && !RD_VALID_O;
  endsequence
  sequence word_out;
    RD_VALID_O && RD_DATA_O == {chan, code};
  endsequence
  start_cause_a: assert property (
    $rose(ADC_START_O) |-> $past(READ_REQ_I))
    else $error("conversion started without a read request");
  one_outstanding_a: assert property (pend |-> !ADC_START_O)
    else $error("second conversion started while one is open");
  chan_range_a: assert property (ADC_START_O |-> ADC_CHAN_O <= 4'h8)
    else $error("conversion channel out of range");
  result_word_a: assert property (conv_done |-> ##[1:3] word_out)
    else $error("result word wrong or late");
  read_hold_a: assert property (RD_VALID_O && !RD_READY_I |=>
    RD_VALID_O && $stable(RD_DATA_O))
    else $error("read word dropped before it was taken");
  reset_idle_a: assert property ($rose(RST_B_I) |->
    CHANNEL_PIN_OE_B_O == 8'hFF && !RD_VALID_O)
    else $error("pins driven or word valid in reset");
  pin_cause_a: assert property ($changed({CHANNEL_PIN_OE_B_O,
    CHANNEL_PIN_OUT_O}) |-> $past(BYTE_VALID_I, 2) ||
    $past(BYTE_VALID_I, 3) || $past(BYTE_VALID_I))
    else $error("pins changed without a write");
  dac_cause_a: assert property ($changed(DAC_VALUE_O) |->
    $past(BYTE_VALID_I) || $past(BYTE_VALID_I, 2))
    else $error("dac value changed without a write");
  cfg_cause_a: assert property (
    $changed({DAC_ENABLE_O, ADC_ENABLE_O})
    |-> $past(BYTE_VALID_I) || $past(BYTE_VALID_I, 2))
    else $error("pin function changed without a write");
endmodule
bind io_channel_config_dac_adc_gpio io_asserts i_io_asserts (.*);

//--- adc_front_model.sv
`timescale 1ns/1ns
module adc_front_model (
  input  wire        clk_i,
  input  wire        rst_b_i,
  input  wire        start_i,
  input  wire [3:0]  chan_i,
  input  wire        slow_i,
  output reg         done_o,
  output reg  [11:0] value_o
);
  // the code carries the channel so a swapped channel shows up
  reg [3:0] wait_cnt;
  reg [3:0] chan;
  reg       busy;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy <= 1'b0;
      wait_cnt <= 4'h0;
      chan <= 4'h0;
      done_o <= 1'b0;
      value_o <= 12'h000;
    end else begin
      done_o <= 1'b0;
      // outside the done pulse the code toggles, never a stale copy
      value_o <= ~value_o;
      if (start_i) begin
        busy <= 1'b1;
        chan <= chan_i;
        wait_cnt <= slow_i ? 4'h9 : 4'h1;
      end else if (busy && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        done_o <= 1'b1;
        value_o <= {4'h6, chan, 4'h9};
      end
    end
  end
endmodule

//--- tb.sv
`timescale 1ns/1ns
module tb;
  reg         clk;
  reg         rst_b;
  reg         frame;
  reg         bvalid;
  reg  [7:0]  byte_d;
  reg         rreq;
  reg         rready;
  reg  [7:0]  pins_in;
  reg         slow;
  wire        adc_done;
  wire [11:0] adc_val;
  wire [15:0] rd_data;
  wire        rd_valid;
  wire        adc_start;
  wire [3:0]  adc_chan;
  wire [95:0] dac_val;
  wire [7:0]  dac_en;
  wire [7:0]  adc_en;
  wire [7:0]  pin_out;
  wire [7:0]  pin_oe_b;
  integer     fail_count;
  integer     n_compared;
  integer     k;
  io_channel_config_dac_adc_gpio i_io_channel_config_dac_adc_gpio (
    .CORE_CLK_I(clk), .RST_B_I(rst_b), .FRAME_START_I(frame),
    .BYTE_VALID_I(bvalid), .BYTE_I(byte_d), .READ_REQ_I(rreq),
    .RD_READY_I(rready), .ADC_DONE_I(adc_done), .ADC_VALUE_I(adc_val),
    .CHANNEL_PIN_IN_I(pins_in), .RD_DATA_O(rd_data),
    .RD_VALID_O(rd_valid), .REQ_READY_O(), .ADC_START_O(adc_start),
    .ADC_CHAN_O(adc_chan), .DAC_VALUE_O(dac_val), .DAC_ENABLE_O(dac_en),
    .ADC_ENABLE_O(adc_en), .CHANNEL_PIN_OUT_O(pin_out),
    .CHANNEL_PIN_OE_B_O(pin_oe_b));
  adc_front_model i_adc_front_model (
    .clk_i(clk), .rst_b_i(rst_b), .start_i(adc_start),
    .chan_i(adc_chan), .slow_i(slow), .done_o(adc_done),
    .value_o(adc_val));
  always #20 clk = ~clk;
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task complete_run;
    begin
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input [15:0] s, input [15:0] e);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // one byte sets only the read pointer, three bytes write a register
  task send(input [7:0] p, input integer n, input [15:0] d);
    begin
      @(posedge clk) frame <= 1'b1;
      @(posedge clk) frame <= 1'b0;
      bvalid <= 1'b1;
      byte_d <= p;
      if (n > 1) begin
        @(posedge clk) byte_d <= d[15:8];
        @(posedge clk) byte_d <= d[7:0];
      end
      @(posedge clk) bvalid <= 1'b0;
      tick(4);
    end
  endtask
  task req;
    begin
      @(posedge clk) rreq <= 1'b1;
      @(posedge clk) rreq <= 1'b0;
      tick(4);
    end
  endtask
  task rd(input [15:0] e);
    integer i;
    begin
      @(posedge clk) rreq <= 1'b1;
      @(posedge clk) rreq <= 1'b0;
      for (i = 0; i < 40 && rd_valid !== 1'b1; i = i + 1)
        @(negedge clk);
      if (rd_valid !== 1'b1) begin
        fail_count = fail_count + 1;
        complete_run;
      end
      chk(rd_data, e);
      @(posedge clk) rready <= 1'b1;
      @(posedge clk) rready <= 1'b0;
      tick(2);
    end
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    frame = 1'b0;
    bvalid = 1'b0;
    byte_d = 8'h00;
    rreq = 1'b0;
    rready = 1'b0;
    pins_in = 8'h00;
    slow = 1'b0;
    fail_count = 0;
    n_compared = 0;
    tick(2);
    rst_b <= 1'b1;
    tick(6);
    chk({8'h00, pin_oe_b}, 16'h00FF);
    send(8'h78, 1, 16'h0000);
    rd(16'h0000);
    $display("reset test done");
    send(8'h05, 3, 16'h0082);
    chk({8'h00, dac_en}, 16'h0082);
    send(8'h04, 3, 16'h0081);
    chk({8'h00, adc_en}, 16'h0081);
    chk({8'h00, dac_en}, 16'h0082);
    send(8'h11, 3, 16'h0ABC);
    chk({4'h0, dac_val[23:12]}, 16'h0ABC);
    send(8'h07, 3, 16'h0001);
    send(8'h12, 3, 16'h0123);
    chk({4'h0, dac_val[35:24]}, 16'h0000);
    send(8'h52, 1, 16'h0000);
    rd(16'hA123);
    send(8'h07, 3, 16'h0002);
    chk({4'h0, dac_val[35:24]}, 16'h0123);
    send(8'h77, 1, 16'h0000);
    rd(16'h0001);
    $display("dac test done");
    send(8'h03, 3, 16'h0080);
    send(8'h05, 3, 16'h00FF);
    chk({8'h00, dac_en}, 16'h0082);
    send(8'h07, 3, 16'h0000);
    send(8'h10, 3, 16'h0555);
    chk({4'h0, dac_val[11:0]}, 16'h0555);
    send(8'h03, 3, 16'h0000);
    $display("lock test done");
    send(8'h52, 1, 16'h0000);
    repeat (9) req;
    k = 0;
    repeat (12) begin
      @(negedge clk);
      if (rd_valid === 1'b1) begin
        k = k + 1;
        chk(rd_data, 16'hA123);
        @(posedge clk) rready <= 1'b1;
        @(posedge clk) rready <= 1'b0;
      end
    end
    chk(k[15:0], 16'h0008);
    $display("fifo test done");
    send(8'h02, 3, 16'h0181);
    send(8'h40, 1, 16'h0000);
    rd(16'h0609);
    slow <= 1'b1;
    rd(16'h7679);
    rd(16'h8689);
    rd(16'h8689);
    send(8'h02, 3, 16'h0281);
    send(8'h40, 1, 16'h0000);
    rd(16'h0609);
    rd(16'h7679);
    rd(16'h0609);
    send(8'h02, 3, 16'h0284);
    send(8'h40, 1, 16'h0000);
    rd(16'h2629);
    send(8'h52, 1, 16'h0000);
    req;
    chk({15'h0000, rd_valid}, 16'h0000);
    send(8'h02, 3, 16'h0000);
    send(8'h52, 1, 16'h0000);
    rd(16'hA123);
    $display("adc test done");
    send(8'h08, 3, 16'h0030);
    send(8'h0C, 3, 16'h0020);
    send(8'h09, 3, 16'h00FF);
    chk({8'h00, pin_oe_b}, 16'h00EF);
    chk({8'h00, pin_out}, 16'h0010);
    send(8'h79, 1, 16'h0000);
    rd(16'h0030);
    send(8'h09, 3, 16'h0000);
    chk({8'h00, pin_oe_b}, 16'h00CF);
    pins_in <= 8'h01;
    send(8'h0A, 3, 16'h0011);
    chk({8'h00, adc_en}, 16'h0080);
    send(8'h60, 1, 16'h0000);
    rd(16'h0001);
    send(8'h09, 3, 16'h0010);
    send(8'h60, 1, 16'h0000);
    rd(16'h0011);
    $display("gpio test done");
    // software reset key clears every register like the reset pin
    send(8'h0F, 3, 16'h0DAC);
    chk({8'h00, pin_oe_b}, 16'h00FF);
    chk({8'h00, dac_en}, 16'h0000);
    chk(dac_val[15:0], 16'h0000);
    send(8'h78, 1, 16'h0000);
    rd(16'h0000);
    $display("soft reset test done");
    complete_run;
  end
endmodule
